// [rtl/jack_irq_pkg.sv]
// Purpose: Shared constants of the headset detection and interrupt unit
// Assumes: Core clock of 40 MHz; 8-bit registers on a paged 7-bit address space
// Notes: Timing counts are derived from times written in their own units
package jack_irq_pkg;
  // Core clock rate
  localparam int unsigned CLK_HZ = 40000000;

  // Register addresses within a page
  localparam logic [6:0] ADDR_PAGE_SEL = 7'h00;
  localparam logic [6:0] ADDR_ANA_PWR = 7'h02;
  localparam logic [6:0] ADDR_FLAGS_A = 7'h2a;
  localparam logic [6:0] ADDR_JACK_FLAGS = 7'h2c;
  localparam logic [6:0] ADDR_FLAGS_B = 7'h2d;
  localparam logic [6:0] ADDR_LIVE_STATUS = 7'h2e;
  localparam logic [6:0] ADDR_IRQ_ONE_CFG = 7'h30;
  localparam logic [6:0] ADDR_IRQ_TWO_CFG = 7'h31;
  localparam logic [6:0] ADDR_PIN_CTRL_A = 7'h34;
  localparam logic [6:0] ADDR_PIN_CTRL_B = 7'h35;
  localparam logic [6:0] ADDR_PIN_CTRL_C = 7'h37;
  localparam logic [6:0] ADDR_JACK_CFG = 7'h43;

  // Pages
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PAGE_ONE = 8'h01;

  // Field positions
  localparam int unsigned ANA_PWR_OFF_BIT = 3;
  localparam int unsigned JCFG_ENABLE_BIT = 1;
  localparam int unsigned JCFG_HS_DEB_LSB = 2;
  localparam int unsigned JCFG_BTN_DEB_LSB = 0;
  localparam int unsigned JCFG_TYPE_LSB = 5;
  localparam int unsigned FLAG_BTN_BIT = 5;
  localparam int unsigned FLAG_HS_BIT = 4;
  localparam int unsigned FLAG_OVF_BIT = 7;
  localparam int unsigned FLAG_CMP_BIT = 7;
  localparam int unsigned FLAG_OVC_BIT = 6;
  localparam int unsigned ICFG_SERIES_BIT = 0;
  localparam int unsigned ICFG_SRC_LSB = 3;
  localparam int unsigned PIN_SEL_LSB = 2;

  // Writable bit masks
  localparam logic [7:0] JCFG_WR_MASK = 8'h1f;

  // Reset values
  localparam logic [7:0] ANA_PWR_RST = 8'h08;
  localparam logic [7:0] REG_ZERO_RST = 8'h00;

  // Pin source selections
  localparam logic [1:0] PIN_SEL_FUNC = 2'h0;
  localparam logic [1:0] PIN_SEL_IRQ_ONE = 2'h1;
  localparam logic [1:0] PIN_SEL_IRQ_TWO = 2'h2;

  // Debounce base step and its cycle count
  localparam int unsigned DEB_UNIT_MS = 8;
  localparam int unsigned DEB_UNIT_CYCLES = DEB_UNIT_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_CNT_W = 25;

  // Interrupt pulse width and pulse-series period
  localparam int unsigned IRQ_PULSE_NS = 2000;
  localparam int unsigned IRQ_PERIOD_NS = 8000;
  localparam int unsigned IRQ_PULSE_CYCLES = (IRQ_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned IRQ_PERIOD_CYCLES = (IRQ_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned IRQ_CNT_W = 10;
endpackage

// [rtl/level_debouncer.sv]
// Purpose: Debounce one raw level against a programmable interval
// Assumes: Raw input is synchronous to the clock
// Notes: State follows raw only after raw stays steady for limit_i cycles
`timescale 1ns/1ps
module level_debouncer #(
  parameter int unsigned CNT_W = 25
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic raw_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic state_o
);
  logic last_q;
  logic state_q;
  logic [CNT_W-1:0] cnt_q;

  // Any change of raw restarts the count; disabled means forced low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_q <= 1'b0;
      state_q <= 1'b0;
      cnt_q <= '0;
    end else if (!enable_i) begin
      last_q <= 1'b0;
      state_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      last_q <= raw_i;
      if (raw_i != last_q || raw_i == state_q) begin
        cnt_q <= '0;
      end else if (cnt_q + 1'b1 >= limit_i) begin
        state_q <= raw_i;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign state_o = state_q;
endmodule

// [rtl/headset_detect_interrupt_unit.sv]
// Purpose: Headset jack and button detection with two configurable interrupt lines
// Assumes: Paged 8-bit register port, one access per strobe, inputs synchronous
// Notes: Sticky flags clear on read; pulse series stops on any flag register read
// Contract
// - Detection runs only while the enable bit 1 of page 0 register 67 is set.
// - Headset insertion and removal are debounced over 32 ms to 512 ms chosen by bits 4:2.
// - Button presses are debounced over 32 ms: bits 1:0 of register 67 pick 8 ms to 32 ms, but bit 1 is also the enable.
// - Register 46 bits 5 and 4 show live button and headset state.
// - A debounced button press sets sticky bit 5 of register 44.
// - A debounced insertion or removal sets sticky bit 4 of register 44.
// - Sticky flags hold until the host reads their register; writes never clear them.
// - Register 67 bits 6:5 report the headset type found at detection.
// - Detection works only while page 1 register 2 bit 3 shows analog power enabled.
// - Two interrupt lines are configured by registers 48 and 49.
// - Each line fires on any selected source among jack, button, compressor, overcurrent, overflow.
// - Registers 52, 53 and 55 route either line to the GPIO, data-out or SPI-out pin.
// - Bit 0 of each line's configuration picks single pulse or pulse series.
// - A pulse series runs until the host reads flag register 42, 44 or 45.
// - Detection is available only while the control interface is in I2C mode.
`timescale 1ns/1ps
module headset_detect_interrupt_unit #(
  parameter int unsigned DEB_UNIT_CYCLES = jack_irq_pkg::DEB_UNIT_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic i2c_mode_i,
  input wire logic jack_raw_i,
  input wire logic button_raw_i,
  input wire logic [1:0] headset_kind_i,
  input wire logic compressor_over_i,
  input wire logic hp_overcurrent_i,
  input wire logic data_overflow_i,
  input wire logic gpio_func_i,
  input wire logic dout_func_i,
  input wire logic miso_func_i,
  output logic irq_line_one_o,
  output logic irq_line_two_o,
  output logic gpio_o,
  output logic dout_o,
  output logic miso_o
);
  localparam int unsigned CW = jack_irq_pkg::DEB_CNT_W;
  localparam int unsigned IW = jack_irq_pkg::IRQ_CNT_W;
  localparam logic [CW-1:0] UNIT = CW'(DEB_UNIT_CYCLES);
  localparam logic [IW-1:0] PULSE_LEN = IW'(jack_irq_pkg::IRQ_PULSE_CYCLES);
  localparam logic [IW-1:0] PERIOD_LEN = IW'(jack_irq_pkg::IRQ_PERIOD_CYCLES);

  logic [7:0] page_q;
  logic [7:0] ana_pwr_q;
  logic [7:0] jack_cfg_q;
  logic [1:0] hs_kind_q;
  logic [7:0] irq_cfg_q [2];
  logic [7:0] pin_ctrl_a_q;
  logic [7:0] pin_ctrl_b_q;
  logic [7:0] pin_ctrl_c_q;
  logic [7:0] rdata_q;
  logic sticky_btn_q;
  logic sticky_hs_q;
  logic sticky_ovf_q;
  logic sticky_cmp_q;
  logic sticky_ovc_q;
  logic hs_state_q;
  logic btn_state_q;
  logic cmp_q;
  logic ovc_q;
  logic ovf_q;
  logic wr_p0;
  logic wr_p1;
  logic rd_p0;
  logic rd_a;
  logic rd_jack;
  logic rd_b;
  logic rd_any_flags;
  logic detect_on;
  logic hs_state;
  logic btn_state;
  logic ev_hs;
  logic ev_btn;
  logic ev_cmp;
  logic ev_ovc;
  logic ev_ovf;
  logic [4:0] ev_vec;
  logic [CW-1:0] hs_limit;
  logic [CW-1:0] btn_limit;
  logic [1:0] irq_out;

  // Access decode; page select lives at address zero of every page
  assign wr_p0 = reg_wr_i && page_q == jack_irq_pkg::PAGE_ZERO;
  assign wr_p1 = reg_wr_i && page_q == jack_irq_pkg::PAGE_ONE;
  assign rd_p0 = reg_rd_i && page_q == jack_irq_pkg::PAGE_ZERO;
  assign rd_a = rd_p0 && reg_addr_i == jack_irq_pkg::ADDR_FLAGS_A;
  assign rd_jack = rd_p0 && reg_addr_i == jack_irq_pkg::ADDR_JACK_FLAGS;
  assign rd_b = rd_p0 && reg_addr_i == jack_irq_pkg::ADDR_FLAGS_B;
  assign rd_any_flags = rd_a || rd_jack || rd_b;

  // Detection gating by enable, analog power (active low bit) and I2C mode
  assign detect_on = jack_cfg_q[jack_irq_pkg::JCFG_ENABLE_BIT]
    && !ana_pwr_q[jack_irq_pkg::ANA_PWR_OFF_BIT]
    && i2c_mode_i;

  // Headset interval doubles per code from 32 ms, capped at 512 ms
  always_comb begin
    hs_limit = UNIT << 2;
    unique case (jack_cfg_q[jack_irq_pkg::JCFG_HS_DEB_LSB +: 3])
      3'h0: hs_limit = UNIT << 2;
      3'h1: hs_limit = UNIT << 3;
      3'h2: hs_limit = UNIT << 4;
      3'h3: hs_limit = UNIT << 5;
      default: hs_limit = UNIT << 6;
    endcase
  end

  // Button interval 8, 16 or 32 ms; the top code repeats 32 ms
  always_comb begin
    btn_limit = UNIT;
    unique case (jack_cfg_q[jack_irq_pkg::JCFG_BTN_DEB_LSB +: 2])
      2'h0: btn_limit = UNIT;
      2'h1: btn_limit = UNIT << 1;
      2'h2: btn_limit = UNIT << 2;
      2'h3: btn_limit = UNIT << 2;
    endcase
  end

  level_debouncer #(.CNT_W(CW)) u_hs_deb (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .enable_i(detect_on),
    .raw_i(jack_raw_i),
    .limit_i(hs_limit),
    .state_o(hs_state)
  );

  // Button only counts while a headset sits in the jack
  level_debouncer #(.CNT_W(CW)) u_btn_deb (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .enable_i(detect_on && hs_state),
    .raw_i(button_raw_i),
    .limit_i(btn_limit),
    .state_o(btn_state)
  );

  // Previous levels for edge detection of all sources
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_state_q <= 1'b0;
      btn_state_q <= 1'b0;
      cmp_q <= 1'b0;
      ovc_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      hs_state_q <= hs_state;
      btn_state_q <= btn_state;
      cmp_q <= compressor_over_i;
      ovc_q <= hp_overcurrent_i;
      ovf_q <= data_overflow_i;
    end
  end

  // Disabling detection drops the state silently, not as a removal event
  assign ev_hs = (hs_state != hs_state_q) && detect_on;
  assign ev_btn = btn_state && !btn_state_q;
  assign ev_cmp = compressor_over_i && !cmp_q;
  assign ev_ovc = hp_overcurrent_i && !ovc_q;
  assign ev_ovf = data_overflow_i && !ovf_q;
  assign ev_vec = {ev_hs, ev_btn, ev_cmp, ev_ovc, ev_ovf};

  // Sticky flags: set wins over the clearing read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sticky_btn_q <= 1'b0;
      sticky_hs_q <= 1'b0;
      sticky_ovf_q <= 1'b0;
      sticky_cmp_q <= 1'b0;
      sticky_ovc_q <= 1'b0;
    end else begin
      sticky_btn_q <= ev_btn || (sticky_btn_q && !rd_jack);
      sticky_hs_q <= ev_hs || (sticky_hs_q && !rd_jack);
      sticky_ovf_q <= ev_ovf || (sticky_ovf_q && !rd_a);
      sticky_cmp_q <= ev_cmp || (sticky_cmp_q && !rd_b);
      sticky_ovc_q <= ev_ovc || (sticky_ovc_q && !rd_b);
    end
  end

  // Headset kind is sampled on insertion and cleared on removal
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_kind_q <= 2'h0;
    end else if (ev_hs) begin
      hs_kind_q <= hs_state ? headset_kind_i : 2'h0;
    end
  end

  // Writable registers; read-only fields are masked out of writes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_q <= jack_irq_pkg::REG_ZERO_RST;
      ana_pwr_q <= jack_irq_pkg::ANA_PWR_RST;
      jack_cfg_q <= jack_irq_pkg::REG_ZERO_RST;
      irq_cfg_q[0] <= jack_irq_pkg::REG_ZERO_RST;
      irq_cfg_q[1] <= jack_irq_pkg::REG_ZERO_RST;
      pin_ctrl_a_q <= jack_irq_pkg::REG_ZERO_RST;
      pin_ctrl_b_q <= jack_irq_pkg::REG_ZERO_RST;
      pin_ctrl_c_q <= jack_irq_pkg::REG_ZERO_RST;
    end else if (reg_wr_i && reg_addr_i == jack_irq_pkg::ADDR_PAGE_SEL) begin
      page_q <= reg_wdata_i;
    end else if (wr_p1 && reg_addr_i == jack_irq_pkg::ADDR_ANA_PWR) begin
      ana_pwr_q <= reg_wdata_i;
    end else if (wr_p0) begin
      unique case (reg_addr_i)
        jack_irq_pkg::ADDR_JACK_CFG: jack_cfg_q <= reg_wdata_i & jack_irq_pkg::JCFG_WR_MASK;
        jack_irq_pkg::ADDR_IRQ_ONE_CFG: irq_cfg_q[0] <= reg_wdata_i;
        jack_irq_pkg::ADDR_IRQ_TWO_CFG: irq_cfg_q[1] <= reg_wdata_i;
        jack_irq_pkg::ADDR_PIN_CTRL_A: pin_ctrl_a_q <= reg_wdata_i;
        jack_irq_pkg::ADDR_PIN_CTRL_B: pin_ctrl_b_q <= reg_wdata_i;
        jack_irq_pkg::ADDR_PIN_CTRL_C: pin_ctrl_c_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Registered read data; unmapped addresses return zero
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= 8'h00;
      if (reg_addr_i == jack_irq_pkg::ADDR_PAGE_SEL) begin
        rdata_q <= page_q;
      end else if (page_q == jack_irq_pkg::PAGE_ONE) begin
        if (reg_addr_i == jack_irq_pkg::ADDR_ANA_PWR) begin
          rdata_q <= ana_pwr_q;
        end
      end else if (page_q == jack_irq_pkg::PAGE_ZERO) begin
        unique case (reg_addr_i)
          jack_irq_pkg::ADDR_FLAGS_A: rdata_q[jack_irq_pkg::FLAG_OVF_BIT] <= sticky_ovf_q;
          jack_irq_pkg::ADDR_JACK_FLAGS: begin
            rdata_q[jack_irq_pkg::FLAG_BTN_BIT] <= sticky_btn_q;
            rdata_q[jack_irq_pkg::FLAG_HS_BIT] <= sticky_hs_q;
          end
          jack_irq_pkg::ADDR_FLAGS_B: begin
            rdata_q[jack_irq_pkg::FLAG_CMP_BIT] <= sticky_cmp_q;
            rdata_q[jack_irq_pkg::FLAG_OVC_BIT] <= sticky_ovc_q;
          end
          jack_irq_pkg::ADDR_LIVE_STATUS: begin
            rdata_q[jack_irq_pkg::FLAG_BTN_BIT] <= btn_state;
            rdata_q[jack_irq_pkg::FLAG_HS_BIT] <= hs_state;
          end
          jack_irq_pkg::ADDR_IRQ_ONE_CFG: rdata_q <= irq_cfg_q[0];
          jack_irq_pkg::ADDR_IRQ_TWO_CFG: rdata_q <= irq_cfg_q[1];
          jack_irq_pkg::ADDR_PIN_CTRL_A: rdata_q <= pin_ctrl_a_q;
          jack_irq_pkg::ADDR_PIN_CTRL_B: rdata_q <= pin_ctrl_b_q;
          jack_irq_pkg::ADDR_PIN_CTRL_C: rdata_q <= pin_ctrl_c_q;
          jack_irq_pkg::ADDR_JACK_CFG: begin
            rdata_q <= jack_cfg_q;
            rdata_q[jack_irq_pkg::JCFG_TYPE_LSB +: 2] <= hs_kind_q;
          end
          default: ;
        endcase
      end
    end
  end

  assign reg_rdata_o = rdata_q;

  // One pulse engine per interrupt line
  for (genvar g = 0; g < 2; g++) begin : g_irq
    logic fire;
    logic series;
    logic pending_q;
    logic [IW-1:0] cnt_q;
    logic out_q;

    assign fire = |(ev_vec & irq_cfg_q[g][jack_irq_pkg::ICFG_SRC_LSB +: 5]);
    assign series = irq_cfg_q[g][jack_irq_pkg::ICFG_SERIES_BIT];

    // Series runs until a flag register is read; a new event wins over that read
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        pending_q <= 1'b0;
      end else begin
        pending_q <= (fire && series) || (pending_q && series && !rd_any_flags);
      end
    end

    // Counter runs one pulse in single mode, or wraps at the period in series mode
    // Both modes keep the line high for counts 0 to PULSE_LEN-1, so a series cut
    // short by a flag read still ends with a full-width pulse
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        cnt_q <= '0;
        out_q <= 1'b0;
      end else if (fire && !out_q && !pending_q) begin
        cnt_q <= '0;
        out_q <= 1'b1;
      end else if (pending_q) begin
        cnt_q <= (cnt_q + 1'b1 >= PERIOD_LEN) ? '0 : cnt_q + 1'b1;
        out_q <= (cnt_q + 1'b1 >= PERIOD_LEN) || (cnt_q + 1'b1 < PULSE_LEN);
      end else if (out_q && cnt_q < PULSE_LEN - IW'(1)) begin
        cnt_q <= cnt_q + 1'b1;
      end else begin
        cnt_q <= '0;
        out_q <= 1'b0;
      end
    end

    assign irq_out[g] = out_q;
  end

  assign irq_line_one_o = irq_out[0];
  assign irq_line_two_o = irq_out[1];

  // Pin routing: each pin picks its normal function or one interrupt line
  function automatic logic pin_mux(input logic [1:0] sel, input logic func, input logic [1:0] irq);
    logic v;
    v = func;
    if (sel == jack_irq_pkg::PIN_SEL_IRQ_ONE) begin
      v = irq[0];
    end else if (sel == jack_irq_pkg::PIN_SEL_IRQ_TWO) begin
      v = irq[1];
    end
    return v;
  endfunction

  assign gpio_o = pin_mux(pin_ctrl_a_q[jack_irq_pkg::PIN_SEL_LSB +: 2], gpio_func_i, irq_out);
  assign dout_o = pin_mux(pin_ctrl_b_q[jack_irq_pkg::PIN_SEL_LSB +: 2], dout_func_i, irq_out);
  assign miso_o = pin_mux(pin_ctrl_c_q[jack_irq_pkg::PIN_SEL_LSB +: 2], miso_func_i, irq_out);
endmodule

// [verification/headset_detect_interrupt_unit_props.sv]
// Purpose: Port-level assertions for the headset detect interrupt unit
// Assumes: Bound to the top module; one clock domain
// Notes: Pulse width uses run counters, as 80 cycles is too long for a repetition
`timescale 1ns/1ps
module headset_detect_interrupt_unit_chk #(
  parameter int unsigned DEB_UNIT_CYCLES = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic gpio_func_i,
  input wire logic dout_func_i,
  input wire logic miso_func_i,
  input wire logic irq_line_one_o,
  input wire logic irq_line_two_o,
  input wire logic gpio_o,
  input wire logic dout_o,
  input wire logic miso_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [9:0] run_one_q;
  logic [9:0] run_two_q;
  // High-time counters, cleared while each line is low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_one_q <= 10'h000;
      run_two_q <= 10'h000;
    end else begin
      run_one_q <= irq_line_one_o ? run_one_q + 10'h001 : 10'h000;
      run_two_q <= irq_line_two_o ? run_two_q + 10'h001 : 10'h000;
    end
  end
  AST_ONE_WIDTH: assert property (
    $fell(irq_line_one_o) |-> run_one_q == 10'(jack_irq_pkg::IRQ_PULSE_CYCLES))
    else $error("line one pulse width wrong");
  AST_TWO_WIDTH: assert property (
    $fell(irq_line_two_o) |-> run_two_q == 10'(jack_irq_pkg::IRQ_PULSE_CYCLES))
    else $error("line two pulse width wrong");
  // A pin leaves its normal function only to carry an interrupt line
  AST_GPIO_ROUTE: assert property (
    gpio_o != gpio_func_i |-> gpio_o == irq_line_one_o || gpio_o == irq_line_two_o)
    else $error("gpio pin drives neither source");
  AST_DOUT_ROUTE: assert property (
    dout_o != dout_func_i |-> dout_o == irq_line_one_o || dout_o == irq_line_two_o)
    else $error("dout pin drives neither source");
  AST_MISO_ROUTE: assert property (
    miso_o != miso_func_i |-> miso_o == irq_line_one_o || miso_o == irq_line_two_o)
    else $error("miso pin drives neither source");
  AST_RDATA_HOLD: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (
    reg_rd_i && reg_addr_i == 7'h7f |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_LIVE_SPARE: assert property (
    reg_rd_i && reg_addr_i == 7'h2e |=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[3:0] == 4'h0)
    else $error("live status spare bits set");
  AST_FLAG_SPARE: assert property (
    reg_rd_i && reg_addr_i == 7'h2c |=> (reg_rdata_o & 8'hcf) == 8'h00)
    else $error("jack flag spare bits set");
  AST_JCFG_TOP: assert property (
    reg_rd_i && reg_addr_i == 7'h43 |=> !reg_rdata_o[7])
    else $error("jack config bit 7 set");
endmodule

// [verification/host_irq_receiver.sv]
// Purpose: Host side that counts interrupt pulses arriving on one pin
// Assumes: Pin is synchronous to the core clock
// Notes: Counts rising edges only, so a stuck-high pin shows as one pulse
`timescale 1ns/1ps
module host_irq_receiver (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output int unsigned pulse_cnt_o
);
  logic pin_q;
  // One count per pulse seen, single or series
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
      pulse_cnt_o <= 0;
    end else begin
      pin_q <= pin_i;
      if (pin_i && !pin_q) begin
        pulse_cnt_o <= pulse_cnt_o + 1;
      end
    end
  end
endmodule

// [verification/headset_detect_interrupt_unit_tb_top.sv]
// Purpose: Register-driven test of jack detection, flags and interrupt lines
// Assumes: Debounce unit shortened to 8 cycles so each interval is a few dozen cycles
// Notes: Each access takes two cycles so strobes never reassert in one time step
`timescale 1ns/1ps
module headset_detect_interrupt_unit_tb_top;
  logic core_clk_i, rst_i, reg_wr_i, reg_rd_i, i2c_mode_i, jack_raw_i, button_raw_i;
  logic [6:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [1:0] headset_kind_i;
  logic compressor_over_i, hp_overcurrent_i, data_overflow_i;
  logic gpio_func_i, dout_func_i, miso_func_i;
  logic irq_line_one_o, irq_line_two_o, gpio_o, dout_o, miso_o;
  int fail_count, total_checks, i, n;
  int unsigned gpio_cnt, dout_cnt, snap;

  headset_detect_interrupt_unit #(.DEB_UNIT_CYCLES(8)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .i2c_mode_i(i2c_mode_i), .jack_raw_i(jack_raw_i), .button_raw_i(button_raw_i),
    .headset_kind_i(headset_kind_i), .compressor_over_i(compressor_over_i),
    .hp_overcurrent_i(hp_overcurrent_i), .data_overflow_i(data_overflow_i),
    .gpio_func_i(gpio_func_i), .dout_func_i(dout_func_i), .miso_func_i(miso_func_i),
    .irq_line_one_o(irq_line_one_o), .irq_line_two_o(irq_line_two_o),
    .gpio_o(gpio_o), .dout_o(dout_o), .miso_o(miso_o));
  host_irq_receiver u_gpio_host (.core_clk_i(core_clk_i), .rst_i(rst_i), .pin_i(gpio_o),
    .pulse_cnt_o(gpio_cnt));
  host_irq_receiver u_dout_host (.core_clk_i(core_clk_i), .rst_i(rst_i), .pin_i(dout_o),
    .pulse_cnt_o(dout_cnt));

  // 40 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // Read data is registered at the taken edge and steady through the next one
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge core_clk_i);
    chk(reg_rdata_o, exp);
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Bounded wait for line one on the gpio pin; n returns the cycles spent
  task automatic wait_gpio;
    for (n = 0; n < 200 && gpio_o !== 1'b1; n++) @(posedge core_clk_i);
    if (gpio_o !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: no interrupt seen", $time);
      results();
    end
  endtask

  // Main sequence
  initial begin
    {reg_wr_i, reg_rd_i, jack_raw_i, button_raw_i, gpio_func_i, dout_func_i} = '0;
    {compressor_over_i, hp_overcurrent_i, data_overflow_i} = '0;
    {i2c_mode_i, miso_func_i, rst_i} = 3'h7;
    reg_addr_i = 7'h00;
    reg_wdata_i = 8'h00;
    headset_kind_i = 2'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd_chk(7'h2c, 8'h00);
    rd_chk(7'h43, 8'h00);
    rd_chk(7'h7f, 8'h00);
    wr(7'h00, 8'h01);
    rd_chk(7'h02, 8'h08);
    wr(7'h00, 8'h00);
    wr(7'h30, 8'h80);
    wr(7'h31, 8'h41);
    wr(7'h34, 8'h04);
    wr(7'h35, 8'h08);
    rd_chk(7'h31, 8'h41);
    rd_chk(7'h34, 8'h04);
    chk({7'h00, miso_o}, 8'h01);
    wr(7'h37, 8'h04);
    wr(7'h43, 8'h02);
    jack_raw_i <= 1'b1;
    repeat (60) @(posedge core_clk_i);
    rd_chk(7'h2e, 8'h00);
    jack_raw_i <= 1'b0;
    wr(7'h00, 8'h01);
    wr(7'h02, 8'h00);
    wr(7'h00, 8'h00);
    repeat (60) @(posedge core_clk_i);
    // A glitch shorter than 32 cycles must be rejected
    jack_raw_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    jack_raw_i <= 1'b0;
    repeat (60) @(posedge core_clk_i);
    rd_chk(7'h2c, 8'h00);
    headset_kind_i <= 2'h2;
    jack_raw_i <= 1'b1;
    wait_gpio();
    chk({7'h00, 1'(n >= 32)}, 8'h01);
    rd_chk(7'h2e, 8'h10);
    wr(7'h43, 8'he2);
    rd_chk(7'h43, 8'h42);
    wr(7'h2e, 8'hff);
    rd_chk(7'h2e, 8'h10);
    rd_chk(7'h2c, 8'h10);
    rd_chk(7'h2c, 8'h00);
    button_raw_i <= 1'b1;
    repeat (60) @(posedge core_clk_i);
    wr(7'h2c, 8'h00);
    rd_chk(7'h2e, 8'h30);
    repeat (700) @(posedge core_clk_i);
    chk({7'h00, 1'(dout_cnt >= 2)}, 8'h01);
    chk(gpio_cnt[7:0], 8'h01);
    rd_chk(7'h2c, 8'h20);
    repeat (100) @(posedge core_clk_i);
    snap = dout_cnt;
    repeat (700) @(posedge core_clk_i);
    chk(dout_cnt[7:0], snap[7:0]);
    // Each remaining source fires line one once in single mode
    wr(7'h30, 8'h38);
    for (i = 0; i < 3; i++) begin
      case (i)
        0: compressor_over_i <= 1'b1;
        1: hp_overcurrent_i <= 1'b1;
        default: data_overflow_i <= 1'b1;
      endcase
      repeat (3) @(posedge core_clk_i);
      {compressor_over_i, hp_overcurrent_i, data_overflow_i} <= 3'h0;
      repeat (100) @(posedge core_clk_i);
      chk(gpio_cnt[7:0], 8'(i + 2));
    end
    rd_chk(7'h2d, 8'hc0);
    rd_chk(7'h2a, 8'h80);
    i2c_mode_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    rd_chk(7'h2e, 8'h00);
    i2c_mode_i <= 1'b1;
    wr(7'h43, 8'h00);
    repeat (60) @(posedge core_clk_i);
    rd_chk(7'h2e, 8'h00);
    results();
  end
endmodule

bind headset_detect_interrupt_unit headset_detect_interrupt_unit_chk #(
  .DEB_UNIT_CYCLES(DEB_UNIT_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .gpio_func_i(gpio_func_i), .dout_func_i(dout_func_i),
  .miso_func_i(miso_func_i), .irq_line_one_o(irq_line_one_o),
  .irq_line_two_o(irq_line_two_o), .gpio_o(gpio_o), .dout_o(dout_o), .miso_o(miso_o));
